// ==== pkg/dacis_if.sv ====
`timescale 1ns/1ns
interface dacis_if;
   logic scl_m_o;   // master clock level when driving
   logic scl_m_oe;  // master drives clock
   logic sda_m_o;   // master data level when driving
   logic sda_m_oe;  // master drives data
   logic sda_d_o;   // device data level when driving
   logic sda_d_oe;  // device drives data
   logic scl;       // resolved clock line
   logic sda;       // resolved data line

   // open-drain wires: pulled up unless a driver pulls low
   assign scl = !(scl_m_oe && !scl_m_o);
   assign sda = !(sda_m_oe && !sda_m_o) && !(sda_d_oe && !sda_d_o);

   modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
   modport master (input scl, input sda, output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe);
endinterface : dacis_if

// ==== pkg/dacis_pkg.sv ====
// Operation
// (RULE1) stop at first mismatching address bit
// (RULE2) address LSB: 0 write, 1 read
// (RULE3) acknowledge matching address in ninth slot
// (RULE4) fixed address bits, A0 from pin
// (RULE5) master sends command byte, then data byte
// (RULE6) commit registers on ack-slot falling edge
// (RULE7) aborted write leaves registers unchanged
// (RULE8) 1100 loads input and DAC registers
// (RULE9) 1101 loads input register only
// (RULE10) 1110 loads input, old input to DAC
// (RULE11) 1111 copies input to DAC, ignores data
// (RULE12) 10xx ignores data, DAC readable
// (RULE13) 01xx top data bits select power-down
// (RULE14) read: byte, master ack, second byte
// (RULE15) general call address is ignored
// (RULE16) only 7-bit addressing supported
// (RULE17) mismatch ignores clock until next START
// (RULE18) reset: zero registers, 100k power-down
// (RULE19) registers kept through power-down
// (RULE20) acknowledge every received byte
// (RULE21) honour STOP except in START's high pulse
// (RULE22) read bytes use write bit positions
// (RULE23) after read NACK release, await START
package dacis_pkg;
   // ***************************************
   // codes and reset values
   // ***************************************
   localparam int         DATA_W        = 10;
   localparam logic [5:0] ADDR_HI_DEF   = 6'h33;  // arbitrary value
   localparam logic [3:0] CMD_LOAD_BOTH = 4'hc;
   localparam logic [3:0] CMD_LOAD_IN   = 4'hd;
   localparam logic [3:0] CMD_LOAD_SWAP = 4'he;
   localparam logic [3:0] CMD_UPDATE    = 4'hf;
   localparam logic [1:0] CMD_READ_PFX  = 2'h2;
   localparam logic [1:0] CMD_PD_PFX    = 2'h1;
   localparam logic [1:0] PD_UP         = 2'h0;
   localparam logic [1:0] PD_FLOAT      = 2'h1;
   localparam logic [1:0] PD_1K         = 2'h2;
   localparam logic [1:0] PD_100K       = 2'h3;
   localparam logic [1:0] PD_RESET      = PD_100K;
   localparam logic [9:0] CODE_RESET    = 10'h000;
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   // ***************************************
   // link timing
   // ***************************************
   localparam int         CLK_PERIOD_NS = 4;
   localparam int         SCL_PERIOD_NS = 2500;
   localparam int         SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam logic [7:0] QTR_LAST      = 8'(SCL_QTR_CYC - 1);
   // ***************************************
   // master register map
   // ***************************************
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_TXDATA    = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_RXDATA    = 8'h0c;
   localparam int         STAT_BUSY     = 0;
   localparam int         STAT_NACK     = 1;
   localparam logic [1:0] LAST_BYTE     = 2'h2;

   typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ADDR_ACK, D_WR, D_WR_ACK, D_RD, D_RD_ACK, D_IGNORE} dacis_dstate_e;
   typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} dacis_mstate_e;
endpackage : dacis_pkg

// ==== rtl/dacis_device.sv ====
`timescale 1ns/1ns
module dacis_device #(
   parameter logic [5:0] ADDR_HI = dacis_pkg::ADDR_HI_DEF  // fixed address bits
) (
   input  wire logic                        CLK,         // system clock
   input  wire logic                        NRST,        // async reset, low
   dacis_if.device                          LINK,        // two-wire link
   input  wire logic                        ADDR_PIN,    // address select pin
   output logic      [dacis_pkg::DATA_W-1:0] DAC_CODE,    // DAC register
   output logic      [dacis_pkg::DATA_W-1:0] INPUT_CODE,  // input register
   output logic      [1:0]                  PD_MODE      // power-down select
);
   import dacis_pkg::*;

   // ***************************************
   // state
   // ***************************************
   logic               scl_s1_r, scl_s1_nxt, scl_s2_r, scl_s2_nxt, scl_d_r, scl_d_nxt;
   logic               sda_s1_r, sda_s1_nxt, sda_s2_r, sda_s2_nxt, sda_d_r, sda_d_nxt;
   logic               pin_s1_r, pin_s1_nxt, pin_s2_r, pin_s2_nxt;
   dacis_dstate_e      state_r, state_nxt;
   logic [3:0]         cnt_r, cnt_nxt;
   logic [7:0]         shift_r, shift_nxt;
   logic [7:0]         cmd_r, cmd_nxt;
   logic               rw_r, rw_nxt;
   logic               idx_r, idx_nxt;
   logic               ack_ok_r, ack_ok_nxt;
   logic               st_hi_r, st_hi_nxt;
   logic               pull_r, pull_nxt;
   logic [DATA_W-1:0]  in_r, in_nxt;
   logic [DATA_W-1:0]  dac_r, dac_nxt;
   logic [1:0]         pd_r, pd_nxt;

   logic               scl_rise, scl_fall, start_cond, stop_cond;
   logic [6:0]         my_addr;
   logic [7:0]         in_byte;
   logic [DATA_W-1:0]  code;
   logic [7:0]         rd_next;

   // ***************************************
   // readback byte layout
   // ***************************************
   function automatic logic [7:0] rd_byte(input logic second, input logic [DATA_W-1:0] val);
      rd_byte = second ? {val[5:0], 2'h0} : {4'h0, val[9:6]};  // see (RULE22)
   endfunction : rd_byte

   assign scl_rise   = scl_s2_r && !scl_d_r;
   assign scl_fall   = !scl_s2_r && scl_d_r;
   assign start_cond = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
   assign stop_cond  = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
   assign my_addr    = {ADDR_HI, pin_s2_r};  // see (RULE4)
   assign in_byte    = {shift_r[6:0], sda_s2_r};
   assign code       = {cmd_r[3:0], shift_r[7:2]};
   assign rd_next    = rd_byte(1'b1, dac_r);

   assign LINK.sda_d_o  = 1'b0;
   assign LINK.sda_d_oe = pull_r;
   assign DAC_CODE      = dac_r;
   assign INPUT_CODE    = in_r;
   assign PD_MODE       = pd_r;

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      scl_s1_nxt = LINK.scl;
      scl_s2_nxt = scl_s1_r;
      scl_d_nxt  = scl_s2_r;
      sda_s1_nxt = LINK.sda;
      sda_s2_nxt = sda_s1_r;
      sda_d_nxt  = sda_s2_r;
      pin_s1_nxt = ADDR_PIN;
      pin_s2_nxt = pin_s1_r;
      state_nxt  = state_r;
      cnt_nxt    = cnt_r;
      shift_nxt  = shift_r;
      cmd_nxt    = cmd_r;
      rw_nxt     = rw_r;
      idx_nxt    = idx_r;
      ack_ok_nxt = ack_ok_r;
      st_hi_nxt  = st_hi_r;
      pull_nxt   = pull_r;
      in_nxt     = in_r;
      dac_nxt    = dac_r;
      pd_nxt     = pd_r;
      if (scl_fall) begin
         st_hi_nxt = 1'b0;
      end
      if (start_cond) begin
         st_hi_nxt = 1'b1;
         state_nxt = D_ADDR;  // see (RULE17)
         cnt_nxt   = 4'h0;
         pull_nxt  = 1'b0;
      end else if (stop_cond && !st_hi_r) begin
         state_nxt = D_IDLE;  // see (RULE21)
         pull_nxt  = 1'b0;
      end else begin
         unique case (state_r)
            D_IDLE, D_IGNORE: begin
               // clock edges are not looked at until the next start, see (RULE17)
               pull_nxt = 1'b0;
            end
            D_ADDR: begin
               if (scl_rise) begin
                  shift_nxt = in_byte;
                  cnt_nxt   = cnt_r + 4'h1;
                  if (cnt_r < 4'h7 && sda_s2_r != my_addr[3'(3'h6 - cnt_r[2:0])]) begin
                     state_nxt = D_IGNORE;  // see (RULE1)
                  end
                  if (cnt_r == 4'h6 && in_byte[6:0] == 7'h00) begin
                     state_nxt = D_IGNORE;  // see (RULE15)
                  end
                  if (cnt_r == 4'h4 && in_byte[4:0] == 5'h1e) begin
                     state_nxt = D_IGNORE;  // see (RULE16)
                  end
               end else if (scl_fall && cnt_r == BYTE_BITS) begin
                  rw_nxt    = shift_r[0];  // see (RULE2)
                  pull_nxt  = 1'b1;        // see (RULE3)
                  state_nxt = D_ADDR_ACK;
               end
            end
            D_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_nxt = 4'h0;
                  idx_nxt = 1'b0;
                  if (rw_r) begin
                     shift_nxt = rd_byte(1'b0, dac_r);  // see (RULE14)
                     pull_nxt  = 1'b1;  // first read bit is a zero pad bit, see (RULE22)
                     state_nxt = D_RD;
                  end else begin
                     pull_nxt  = 1'b0;
                     state_nxt = D_WR;
                  end
               end
            end
            D_WR: begin
               if (scl_rise) begin
                  shift_nxt = in_byte;
                  cnt_nxt   = cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == BYTE_BITS) begin
                  pull_nxt  = 1'b1;  // see (RULE20)
                  state_nxt = D_WR_ACK;
               end
            end
            D_WR_ACK: begin
               if (scl_fall) begin
                  pull_nxt  = 1'b0;
                  cnt_nxt   = 4'h0;
                  state_nxt = D_WR;
                  idx_nxt   = !idx_r;
                  if (!idx_r) begin
                     cmd_nxt = shift_r;
                  end else begin
                     // commit only once both bytes arrived, see (RULE6) (RULE7)
                     if (cmd_r[7:4] == CMD_LOAD_BOTH) begin
                        in_nxt  = code;  // see (RULE8)
                        dac_nxt = code;
                     end else if (cmd_r[7:4] == CMD_LOAD_IN) begin
                        in_nxt = code;   // see (RULE9)
                     end else if (cmd_r[7:4] == CMD_LOAD_SWAP) begin
                        in_nxt  = code;  // see (RULE10)
                        dac_nxt = in_r;
                     end else if (cmd_r[7:4] == CMD_UPDATE) begin
                        dac_nxt = in_r;  // see (RULE11)
                     end else if (cmd_r[7:6] == CMD_PD_PFX) begin
                        pd_nxt = cmd_r[3:2];  // see (RULE13) (RULE19)
                     end
                     // read request prefix changes nothing; reads always return the DAC register, see (RULE12)
                  end
               end
            end
            D_RD: begin
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], 1'b0};
                  cnt_nxt   = cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_r == BYTE_BITS) begin
                     pull_nxt  = 1'b0;
                     state_nxt = D_RD_ACK;
                  end else begin
                     pull_nxt = !shift_r[7];
                  end
               end
            end
            D_RD_ACK: begin
               if (scl_rise) begin
                  ack_ok_nxt = !sda_s2_r;
               end else if (scl_fall) begin
                  cnt_nxt = 4'h0;
                  if (ack_ok_r && !idx_r) begin
                     idx_nxt   = 1'b1;  // see (RULE14)
                     shift_nxt = rd_next;
                     pull_nxt  = !rd_next[7];
                     state_nxt = D_RD;
                  end else begin
                     pull_nxt  = 1'b0;  // see (RULE23)
                     state_nxt = D_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r  <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r  <= 1'b1;
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         state_r  <= D_IDLE;
         cnt_r    <= 4'h0;
         shift_r  <= 8'h00;
         cmd_r    <= 8'h00;
         rw_r     <= 1'b0;
         idx_r    <= 1'b0;
         ack_ok_r <= 1'b0;
         st_hi_r  <= 1'b0;
         pull_r   <= 1'b0;
         in_r     <= CODE_RESET;  // see (RULE18)
         dac_r    <= CODE_RESET;
         pd_r     <= PD_RESET;
      end else begin
         scl_s1_r <= scl_s1_nxt;
         scl_s2_r <= scl_s2_nxt;
         scl_d_r  <= scl_d_nxt;
         sda_s1_r <= sda_s1_nxt;
         sda_s2_r <= sda_s2_nxt;
         sda_d_r  <= sda_d_nxt;
         pin_s1_r <= pin_s1_nxt;
         pin_s2_r <= pin_s2_nxt;
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         shift_r  <= shift_nxt;
         cmd_r    <= cmd_nxt;
         rw_r     <= rw_nxt;
         idx_r    <= idx_nxt;
         ack_ok_r <= ack_ok_nxt;
         st_hi_r  <= st_hi_nxt;
         pull_r   <= pull_nxt;
         in_r     <= in_nxt;
         dac_r    <= dac_nxt;
         pd_r     <= pd_nxt;
      end
   end
endmodule : dacis_device

// ==== rtl/dacis_master.sv ====
`timescale 1ns/1ns
module dacis_master (
   input  wire logic        CLK,        // system clock
   input  wire logic        NRST,       // async reset, low
   dacis_if.master          LINK,       // two-wire link
   input  wire logic [7:0]  BUS_ADDR,   // register byte address
   input  wire logic [31:0] BUS_WDATA,  // write data
   input  wire logic        BUS_WR,     // write strobe
   input  wire logic        BUS_RD,     // read strobe
   output logic      [31:0] BUS_RDATA   // read data, cycle after strobe
);
   import dacis_pkg::*;

   // ***************************************
   // state
   // ***************************************
   logic          sda_s1_r, sda_s1_nxt, sda_s2_r, sda_s2_nxt;
   dacis_mstate_e state_r, state_nxt;
   logic [7:0]    qcnt_r, qcnt_nxt;
   logic [1:0]    ph_r, ph_nxt;
   logic [1:0]    byte_r, byte_nxt;
   logic [3:0]    pos_r, pos_nxt;
   logic          scl_pull_r, scl_pull_nxt;
   logic          sda_pull_r, sda_pull_nxt;
   logic [7:0]    abyte_r, abyte_nxt;
   logic [15:0]   tx_r, tx_nxt;
   logic [15:0]   rx_r, rx_nxt;
   logic          nack_r, nack_nxt;
   logic [31:0]   rdata_r, rdata_nxt;

   logic          tick, rd, drive, val, slave_acks;
   logic [7:0]    cur;

   assign tick       = qcnt_r == QTR_LAST;
   assign rd         = abyte_r[0];  // see (RULE2)
   assign cur        = (byte_r == 2'h0) ? abyte_r : ((byte_r == 2'h1) ? tx_r[15:8] : tx_r[7:0]);
   assign slave_acks = byte_r == 2'h0 || !rd;
   // master acks first read byte, not-acks the last, see (RULE14)
   assign drive      = (pos_r == BYTE_BITS) ? !slave_acks : slave_acks;
   assign val        = (pos_r == BYTE_BITS) ? (byte_r == LAST_BYTE) : cur[3'(3'h7 - pos_r[2:0])];

   assign LINK.scl_m_o  = 1'b0;
   assign LINK.scl_m_oe = scl_pull_r;
   assign LINK.sda_m_o  = 1'b0;
   assign LINK.sda_m_oe = sda_pull_r;
   assign BUS_RDATA     = rdata_r;

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      sda_s1_nxt   = LINK.sda;
      sda_s2_nxt   = sda_s1_r;
      state_nxt    = state_r;
      qcnt_nxt     = (state_r == M_IDLE || tick) ? 8'h00 : qcnt_r + 8'h01;
      ph_nxt       = ph_r;
      byte_nxt     = byte_r;
      pos_nxt      = pos_r;
      scl_pull_nxt = scl_pull_r;
      sda_pull_nxt = sda_pull_r;
      abyte_nxt    = abyte_r;
      tx_nxt       = tx_r;
      rx_nxt       = rx_r;
      nack_nxt     = nack_r;
      rdata_nxt    = 32'h0000_0000;
      if (BUS_WR && state_r == M_IDLE) begin
         if (BUS_ADDR == REG_CTRL) begin
            abyte_nxt = BUS_WDATA[7:0];
            nack_nxt  = 1'b0;
            ph_nxt    = 2'h0;
            state_nxt = M_START;
         end else if (BUS_ADDR == REG_TXDATA) begin
            tx_nxt = BUS_WDATA[15:0];  // see (RULE5)
         end
      end
      if (BUS_RD) begin
         if (BUS_ADDR == REG_CTRL) begin
            rdata_nxt = {24'h00_0000, abyte_r};
         end else if (BUS_ADDR == REG_TXDATA) begin
            rdata_nxt = {16'h0000, tx_r};
         end else if (BUS_ADDR == REG_STATUS) begin
            rdata_nxt[STAT_BUSY] = state_r != M_IDLE;
            rdata_nxt[STAT_NACK] = nack_r;
         end else if (BUS_ADDR == REG_RXDATA) begin
            rdata_nxt = {16'h0000, rx_r};
         end
      end
      if (tick) begin
         ph_nxt = ph_r + 2'h1;
         unique case (state_r)
            M_IDLE: begin
               ph_nxt = 2'h0;
            end
            M_START: begin
               if (ph_r == 2'h0) begin
                  sda_pull_nxt = 1'b1;
               end else begin
                  scl_pull_nxt = 1'b1;
                  byte_nxt     = 2'h0;
                  pos_nxt      = 4'h0;
                  ph_nxt       = 2'h0;
                  state_nxt    = M_BIT;
               end
            end
            M_BIT: begin
               unique case (ph_r)
                  2'h0: sda_pull_nxt = drive && !val;
                  2'h1: scl_pull_nxt = 1'b0;
                  2'h2: begin
                     if (pos_r == BYTE_BITS) begin
                        nack_nxt = slave_acks && sda_s2_r;
                     end else if (!slave_acks) begin
                        rx_nxt = {rx_r[14:0], sda_s2_r};
                     end
                  end
                  2'h3: begin
                     scl_pull_nxt = 1'b1;
                     if (pos_r == BYTE_BITS) begin
                        pos_nxt  = 4'h0;
                        byte_nxt = byte_r + 2'h1;
                        if (nack_r || byte_r == LAST_BYTE) begin
                           state_nxt = M_STOP;
                        end
                     end else begin
                        pos_nxt = pos_r + 4'h1;
                     end
                  end
               endcase
            end
            M_STOP: begin
               if (ph_r == 2'h0) begin
                  sda_pull_nxt = 1'b1;
               end else if (ph_r == 2'h1) begin
                  scl_pull_nxt = 1'b0;
               end else begin
                  sda_pull_nxt = 1'b0;
                  state_nxt    = M_IDLE;
               end
            end
         endcase
      end
   end

   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sda_s1_r   <= 1'b1;
         sda_s2_r   <= 1'b1;
         state_r    <= M_IDLE;
         qcnt_r     <= 8'h00;
         ph_r       <= 2'h0;
         byte_r     <= 2'h0;
         pos_r      <= 4'h0;
         scl_pull_r <= 1'b0;
         sda_pull_r <= 1'b0;
         abyte_r    <= 8'h00;
         tx_r       <= 16'h0000;
         rx_r       <= 16'h0000;
         nack_r     <= 1'b0;
         rdata_r    <= 32'h0000_0000;
      end else begin
         sda_s1_r   <= sda_s1_nxt;
         sda_s2_r   <= sda_s2_nxt;
         state_r    <= state_nxt;
         qcnt_r     <= qcnt_nxt;
         ph_r       <= ph_nxt;
         byte_r     <= byte_nxt;
         pos_r      <= pos_nxt;
         scl_pull_r <= scl_pull_nxt;
         sda_pull_r <= sda_pull_nxt;
         abyte_r    <= abyte_nxt;
         tx_r       <= tx_nxt;
         rx_r       <= rx_nxt;
         nack_r     <= nack_nxt;
         rdata_r    <= rdata_nxt;
      end
   end
endmodule : dacis_master

// ==== verification/dac_i2c_command_slave_tb_top.sv ====
`timescale 1ns/1ns
module dac_i2c_command_slave_tb_top;
   import dacis_pkg::*;
   localparam logic [6:0] ADDR7 = {ADDR_HI_DEF, 1'b1};
   logic              clk, nrst, bus_wr, bus_rd, addr_pin;
   logic [7:0]        bus_addr;
   logic [31:0]       bus_wdata, bus_rdata, rd_v;
   logic [DATA_W-1:0] dac_code, input_code;
   logic [1:0]        pd_mode;
   int                mismatches, n_checks;
   dacis_if link();
   dacis_master dacis_master_i (.CLK(clk), .NRST(nrst), .LINK(link.master), .BUS_ADDR(bus_addr),
      .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata));
   dacis_device #(.ADDR_HI(ADDR_HI_DEF)) dacis_device_i (.CLK(clk), .NRST(nrst), .LINK(link.device),
      .ADDR_PIN(addr_pin), .DAC_CODE(dac_code), .INPUT_CODE(input_code), .PD_MODE(pd_mode));
   dacis_monitor #(.ADDR7(ADDR7)) dacis_monitor_i (.CLK(clk), .NRST(nrst), .scl(link.scl), .sda(link.sda),
      .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe));
   // ****************************************
   // tasks
   // ****************************************
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask : bus_write
   task bus_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask : bus_read
   // one whole frame: data word first, then address and direction
   task frame(input logic [7:0] ctrl, input logic [15:0] tx);
      int i;
      bus_write(REG_TXDATA, {16'h0000, tx});
      bus_write(REG_CTRL, {24'h000000, ctrl});
      rd_v = 32'h00000001;
      for (i = 0; i < 40000 && rd_v[STAT_BUSY] !== 1'b0; i++) bus_read(REG_STATUS, rd_v);
      chk({31'h0, rd_v[STAT_BUSY]}, 32'h0);
   endtask : frame
   task codes(input logic [9:0] dac, input logic [9:0] inp, input logic [1:0] pd);
      chk({22'h0, dac_code}, {22'h0, dac});
      chk({22'h0, input_code}, {22'h0, inp});
      chk({30'h0, pd_mode}, {30'h0, pd});
   endtask : codes
   task give_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   // ****************************************
   // clock, watchdog, tests
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      give_verdict;
   end
   initial begin
      nrst = 1'b0; bus_wr = 1'b0; bus_rd = 1'b0; bus_addr = 8'h00; bus_wdata = 32'h0; addr_pin = 1'b1;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      codes(10'h000, 10'h000, PD_100K);
      $display("test reset done");
      frame({ADDR7, 1'b0}, {CMD_LOAD_IN, 10'h2aa, 2'b00});
      codes(10'h000, 10'h2aa, PD_100K);
      $display("test load input done");
      frame({ADDR7, 1'b0}, {CMD_LOAD_SWAP, 10'h155, 2'b00});
      codes(10'h2aa, 10'h155, PD_100K);
      chk({31'h0, rd_v[STAT_NACK]}, 32'h0);
      $display("test swap done");
      frame({ADDR7, 1'b1}, 16'h0000);
      bus_read(REG_RXDATA, rd_v);
      chk(rd_v, {18'h0, 10'h2aa, 2'b00});
      $display("test read done");
      frame({ADDR7 ^ 7'h02, 1'b0}, {CMD_LOAD_BOTH, 10'h3ff, 2'b00});
      chk({31'h0, rd_v[STAT_NACK]}, 32'h1);
      codes(10'h2aa, 10'h155, PD_100K);
      $display("test foreign address done");
      frame({ADDR7, 1'b0}, {CMD_PD_PFX, 2'b00, PD_UP, 10'h000});
      codes(10'h2aa, 10'h155, PD_UP);
      $display("test power up done");
      give_verdict;
   end
endmodule : dac_i2c_command_slave_tb_top

// ==== verification/dacis_monitor.sv ====
`timescale 1ns/1ns
module dacis_monitor #(
   parameter logic [6:0] ADDR7 = 7'h00  // expected slave address
) (
   input wire logic CLK,       // system clock
   input wire logic NRST,      // async reset, low
   input wire logic scl,       // resolved clock line
   input wire logic sda,       // resolved data line
   input wire logic sda_d_o,   // device data level
   input wire logic sda_d_oe   // device drives data
);
   logic [4:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic       scl_r, sda_r;
   // ****************************************
   // bit slot count and shifted byte since START
   // ****************************************
   always_comb begin
      cnt_nxt = cnt_r;
      sh_nxt  = sh_r;
      if (scl && !scl_r) begin
         sh_nxt = {sh_r[6:0], sda};
         if (cnt_r != 5'h1f) cnt_nxt = cnt_r + 5'h01;
      end
      if (scl && scl_r && sda_r && !sda) cnt_nxt = 5'h00;
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cnt_r <= 5'h00;
         sh_r  <= 8'h00;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         sh_r  <= sh_nxt;
         scl_r <= scl;
         sda_r <= sda;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   property p_dev_pull_only; sda_d_oe |-> !sda_d_o; endproperty
   a_dev_pull_only: assert property (p_dev_pull_only) else $error("device drives data high");
   property p_dev_change_low; $changed(sda_d_oe) |-> !scl; endproperty
   a_dev_change_low: assert property (p_dev_change_low) else $error("device data moved in clock high");
   property p_start_idle; $fell(sda) && scl |-> !sda_d_oe; endproperty
   a_start_idle: assert property (p_start_idle) else $error("device busy at start");
   property p_addr_quiet; cnt_r < 5'h08 |-> !sda_d_oe; endproperty
   a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address");
   property p_addr_ack; $fell(scl) && cnt_r == 5'h08 && sh_r[7:1] == ADDR7 |-> ##[1:8] sda_d_oe; endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("matching address not acknowledged");
   property p_mism_quiet; $fell(scl) && cnt_r == 5'h08 && sh_r[7:1] != ADDR7 |-> ##8 !sda_d_oe [*8]; endproperty
   a_mism_quiet: assert property (p_mism_quiet) else $error("foreign address acknowledged");
   property p_stop_free; $rose(sda) && scl |=> !sda_d_oe [*8]; endproperty
   a_stop_free: assert property (p_stop_free) else $error("device holds line after stop");
   property p_ack_held; $rose(scl) && sda_d_oe |=> sda_d_oe [*8]; endproperty
   a_ack_held: assert property (p_ack_held) else $error("device pull dropped in clock high");
endmodule : dacis_monitor
